// File: rtl/sid_control.sv
`timescale 1ns/1ps
module sid_control
  import sid_ctrl_pkg::*;
(
  input wire logic SYS_CLK, // System clock, 100 MHz
  input wire logic NRST, // Async reset, low
  input wire logic CONTROL_SHIFT_CLOCK, // Processor shift clock
  input wire logic PORT_SEL_N, // Port select, low
  input wire logic CMD_SERIAL_IN, // Command bits in
  output logic STATUS_SERIAL_OUT, // Status bits out
  output logic STATUS_SERIAL_OE, // Status pin drive
  output logic ATTN_N_O, // Attention level
  output logic ATTN_N_OE, // Attention pull-down enable
  output logic LINE_SIGNAL_DETECT_N_O, // Detect level
  output logic LINE_SIGNAL_DETECT_N_OE, // Detect pull-down enable
  input wire logic LINE_ENERGY, // Raw line detector
  input wire info_t RX_INFO, // Received INFO class
  output info_t TX_INFO, // INFO to transmit
  input wire logic TRANSMIT_BIT_CLOCK_EDGE, // Transmit bit edge pulse
  input wire logic RECOVERED_EDGE, // DPLL recovered edge
  output logic RX_SAMPLE, // Receive sample strobe
  output logic RX_ADAPTIVE, // DPLL follows line data
  output logic EQ_EN, // Receive equalizer on
  output logic POWERED, // Device powered up
  output mode_t MODE, // Device mode
  output cfg_t CFG // Group settings
);
  // Shift-clock domain
  logic link_clr_n;
  logic [3:0] bit_cnt_reg;
  logic [2:0] out_idx_reg;
  logic [7:0] cmd_shift_reg;
  logic done_tgl_reg;
  logic edge_tgl_reg;
  // System domain
  logic sel_idle;
  logic done_s;
  logic edge_s;
  logic line_s;
  logic done_seen_reg;
  logic edge_seen_reg;
  logic byte_rdy_reg;
  logic accept;
  logic frozen;
  logic cmd_go_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_word_reg;
  logic [7:0] status_reg;
  logic pending_reg;
  logic late_reg;
  logic attn_reg;
  logic detect_hold_reg;
  logic is_nt;
  logic fixed;
  logic is_act_req;
  logic ev_valid;
  logic [7:0] ev_code;
  logic rx_lost_prev_reg;
  logic [8:0] smp_cnt_reg;
  act_state_t st_reg;
  act_state_t st_next;
  mode_t mode_reg;
  cfg_t cfg_reg;
  info_t tx_info_reg;
  logic rx_sample_reg;
  logic eq_reg;

  // Frame counters clear while select is high
  assign link_clr_n = NRST & ~PORT_SEL_N;

  always_ff @(posedge CONTROL_SHIFT_CLOCK or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_cnt_reg <= 4'h0;
    end else if (bit_cnt_reg != BYTE_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // rising-edge sampling; bits past eight ignored
  always_ff @(posedge CONTROL_SHIFT_CLOCK or negedge NRST) begin
    if (!NRST) begin
      cmd_shift_reg <= 8'hFF;
    end else if (!PORT_SEL_N && bit_cnt_reg != BYTE_BITS) begin
      cmd_shift_reg <= {cmd_shift_reg[6:0], CMD_SERIAL_IN};
    end
  end

  // only the eighth bit flags a full byte
  always_ff @(posedge CONTROL_SHIFT_CLOCK or negedge NRST) begin
    if (!NRST) begin
      done_tgl_reg <= 1'b0;
    end else if (!PORT_SEL_N && bit_cnt_reg == BYTE_BITS - 4'h1) begin
      done_tgl_reg <= ~done_tgl_reg;
    end
  end

  // first rising edge of a frame, passed as a toggle
  always_ff @(posedge CONTROL_SHIFT_CLOCK or negedge NRST) begin
    if (!NRST) begin
      edge_tgl_reg <= 1'b0;
    end else if (!PORT_SEL_N && bit_cnt_reg == 4'h0) begin
      edge_tgl_reg <= ~edge_tgl_reg;
    end
  end

  // falling edges step the status bit index
  always_ff @(negedge CONTROL_SHIFT_CLOCK or negedge link_clr_n) begin
    if (!link_clr_n) begin
      out_idx_reg <= 3'h0;
    end else if (out_idx_reg != 3'h7) begin
      out_idx_reg <= out_idx_reg + 3'h1;
    end
  end

  // status word is frozen for the whole frame, msb first
  assign STATUS_SERIAL_OUT = tx_word_reg[3'h7 - out_idx_reg];
  assign STATUS_SERIAL_OE = ~PORT_SEL_N;

  // Crossings into the system clock
  level_sync #(.RESET_VAL(1'b1)) u_sel_sync (.clk(SYS_CLK), .rst_n(NRST), .din(PORT_SEL_N), .dout(sel_idle));
  level_sync #(.RESET_VAL(1'b0)) u_done_sync (.clk(SYS_CLK), .rst_n(NRST), .din(done_tgl_reg), .dout(done_s));
  level_sync #(.RESET_VAL(1'b0)) u_edge_sync (.clk(SYS_CLK), .rst_n(NRST), .din(edge_tgl_reg), .dout(edge_s));
  level_sync #(.RESET_VAL(1'b0)) u_line_sync (.clk(SYS_CLK), .rst_n(NRST), .din(LINE_ENERGY), .dout(line_s));

  // Toggle history for edge detection
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      done_seen_reg <= 1'b0;
      edge_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= done_s;
      edge_seen_reg <= edge_s;
    end
  end

  // full byte waits for select to close
  assign accept = byte_rdy_reg & sel_idle;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      byte_rdy_reg <= 1'b0;
    end else if (done_s != done_seen_reg) begin
      byte_rdy_reg <= 1'b1;
    end else if (accept) begin
      byte_rdy_reg <= 1'b0;
    end
  end

  // Shift register is quiet once select is high
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_go_reg <= 1'b0;
      cmd_reg <= CMD_IDLE;
    end else begin
      cmd_go_reg <= accept;
      if (accept) begin
        cmd_reg <= cmd_shift_reg;
      end
    end
  end

  assign is_act_req = cmd_go_reg && cmd_reg == CMD_ACT_REQ;
  // mode picks timing and activation behaviour
  assign is_nt = mode_reg == MODE_NET_ADAPT || mode_reg == MODE_NET_FIXED;
  assign fixed = mode_reg == MODE_NET_FIXED;

  // each group keeps only its latest command
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_reg <= MODE_RESET;
      cfg_reg <= CFG_RESET;
    end else if (cmd_go_reg) begin
      if (cmd_reg[7:2] == CMD_MODE_GRP) begin
        mode_reg <= mode_t'(cmd_reg[1:0]);
      end
      if (cmd_reg[7:2] == CMD_FMT_GRP) begin
        cfg_reg.fmt <= cmd_reg[1:0];
      end
      if (cmd_reg >= CMD_LOOP_LO && cmd_reg <= CMD_LOOP_HI) begin
        cfg_reg.loop_sel <= cmd_reg[2:0];
      end
      // idle command falls through untouched
      // Empty default, so format and loop updates above survive
      case (cmd_reg)
        CMD_B1_ON: cfg_reg.b1_en <= 1'b1;
        CMD_B1_OFF: cfg_reg.b1_en <= 1'b0;
        CMD_B2_ON: cfg_reg.b2_en <= 1'b1;
        CMD_B2_OFF: cfg_reg.b2_en <= 1'b0;
        CMD_B_SWAP: cfg_reg.b_swap <= ~cfg_reg.b_swap;
        CMD_EOM_IRQ_ON: cfg_reg.eom_ie <= 1'b1;
        CMD_EOM_IRQ_OFF: cfg_reg.eom_ie <= 1'b0;
        CMD_MF_IRQ_ON: cfg_reg.mf_ie <= 1'b1;
        CMD_MF_IRQ_OFF: cfg_reg.mf_ie <= 1'b0;
        default: ;
      endcase
    end
  end

  // Activation sequencing and status events
  always_comb begin
    st_next = st_reg;
    ev_valid = 1'b0;
    ev_code = STAT_NONE;
    case (st_reg)
      S_DOWN: begin
        if (cmd_go_reg && cmd_reg == CMD_POWER_UP) begin
          st_next = S_IDLE;
        end else if (line_s && !detect_hold_reg) begin
          ev_valid = 1'b1;
          ev_code = STAT_LINE_DET;
        end
      end
      S_IDLE: begin
        if (is_act_req) begin
          st_next = is_nt ? S_SYNC : S_REQ;
        end else if (RX_INFO == (is_nt ? INFO_1 : INFO_2)) begin
          st_next = S_PEND;
          ev_valid = 1'b1;
          ev_code = STAT_ACT_PEND;
        end
      end
      S_PEND: begin
        if (is_act_req) begin
          st_next = S_SYNC;
        end
      end
      S_REQ: begin
        // INFO2 seen, move on to INFO3
        if (RX_INFO == INFO_2) begin
          st_next = S_SYNC;
        end
      end
      S_SYNC: begin
        if (is_nt && RX_INFO == INFO_3) begin
          st_next = S_ARM;
          ev_valid = 1'b1;
          ev_code = STAT_ACT_IND;
        end else if (!is_nt && RX_INFO == INFO_4) begin
          st_next = S_ACT;
          ev_valid = 1'b1;
          ev_code = STAT_ACT_IND;
        end
      end
      S_ARM: begin
        if (is_act_req) begin
          st_next = S_ACT;
          ev_valid = 1'b1;
          ev_code = STAT_ACT_IND;
        end
      end
      S_ACT: begin
        if (RX_INFO == INFO_0) begin
          st_next = S_IDLE;
          ev_valid = 1'b1;
          ev_code = STAT_LINK_DOWN;
        end else if (RX_INFO == INFO_LOST && !rx_lost_prev_reg) begin
          ev_valid = 1'b1;
          ev_code = STAT_ERR;
        end
      end
      default: st_next = S_DOWN;
    endcase
    // Deactivate and power-down override any step
    if (cmd_go_reg && cmd_reg == CMD_DEACT_REQ && st_reg != S_DOWN) begin
      st_next = S_IDLE;
    end
    if (cmd_go_reg && cmd_reg == CMD_POWER_DOWN) begin
      st_next = S_DOWN;
    end
  end

  // State, lost-framing history
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= S_DOWN;
      rx_lost_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      rx_lost_prev_reg <= RX_INFO == INFO_LOST;
    end
  end

  // Line signal per state and mode
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_info_reg <= INFO_0;
    end else begin
      case (st_reg)
        S_REQ: tx_info_reg <= INFO_1;
        S_SYNC: tx_info_reg <= is_nt ? INFO_2 : INFO_3;
        S_ARM: tx_info_reg <= INFO_2;
        S_ACT: tx_info_reg <= is_nt ? INFO_4 : INFO_3;
        default: tx_info_reg <= INFO_0;
      endcase
    end
  end

  // detect pin held only while powered down
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      detect_hold_reg <= 1'b0;
    end else if (ev_valid && ev_code == STAT_LINE_DET) begin
      detect_hold_reg <= 1'b1;
    end else if (st_reg != S_DOWN) begin
      detect_hold_reg <= 1'b0;
    end
  end

  // Status word freezes from select low until the byte is taken
  assign frozen = ~sel_idle | byte_rdy_reg;

  // latest change or all zeros; new event always wins the clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      status_reg <= STAT_NONE;
      pending_reg <= 1'b0;
      late_reg <= 1'b0;
      tx_word_reg <= STAT_NONE;
    end else begin
      if (ev_valid) begin
        status_reg <= ev_code;
      end
      if (ev_valid) begin
        pending_reg <= 1'b1;
      end else if (accept) begin
        pending_reg <= late_reg;
      end
      // An event at accept is pending already; marking it late would repeat it
      if (ev_valid && frozen && !accept) begin
        late_reg <= 1'b1;
      end else if (accept) begin
        late_reg <= 1'b0;
      end
      if (!frozen) begin
        tx_word_reg <= ev_valid ? ev_code : (pending_reg ? status_reg : STAT_NONE);
      end
    end
  end

  // raise on change. any frame's first edge releases
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      attn_reg <= 1'b0;
    end else if (ev_valid) begin
      attn_reg <= 1'b1;
    end else if (edge_s != edge_seen_reg) begin
      attn_reg <= 1'b0;
    end
  end

  // fixed mode counts the offset after each transmit edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      smp_cnt_reg <= 9'h000;
    end else if (fixed && TRANSMIT_BIT_CLOCK_EDGE) begin
      smp_cnt_reg <= SAMPLE_LOAD;
    end else if (smp_cnt_reg != 9'h000) begin
      smp_cnt_reg <= smp_cnt_reg - 9'h001;
    end
  end

  // adaptive mode passes the recovered timing; equalizer off when fixed
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_sample_reg <= 1'b0;
      eq_reg <= 1'b0;
    end else begin
      rx_sample_reg <= fixed ? smp_cnt_reg == 9'h001 : RECOVERED_EDGE;
      eq_reg <= !fixed && st_reg != S_DOWN;
    end
  end

  assign ATTN_N_O = 1'b0;
  assign ATTN_N_OE = attn_reg;
  assign LINE_SIGNAL_DETECT_N_O = 1'b0;
  assign LINE_SIGNAL_DETECT_N_OE = detect_hold_reg;
  assign TX_INFO = tx_info_reg;
  assign RX_SAMPLE = rx_sample_reg;
  assign RX_ADAPTIVE = ~fixed;
  assign EQ_EN = eq_reg;
  assign POWERED = st_reg != S_DOWN;
  assign MODE = mode_reg;
  assign CFG = cfg_reg;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence te_req_idle;
    is_act_req && st_reg == S_IDLE && !is_nt;
  endsequence
  sequence line_seen;
    st_reg == S_DOWN && line_s && !detect_hold_reg && !cmd_go_reg;
  endsequence
  sequence powerup_taken;
    cmd_go_reg && cmd_reg == CMD_POWER_UP && st_reg == S_DOWN;
  endsequence

  attn_raise_a: assert property (ev_valid |=> ATTN_N_OE) else $error("attention not raised");
  attn_release_a: assert property ((edge_s != edge_seen_reg && !ev_valid) |=> !ATTN_N_OE)
    else $error("attention not released");
  status_zero_a: assert property ((!frozen && !ev_valid && !pending_reg) |=> tx_word_reg == 8'h00)
    else $error("idle status not zero");
  whole_byte_a: assert property (cmd_go_reg |-> $past(byte_rdy_reg) && $past(sel_idle))
    else $error("command taken without full frame");
  detect_pull_a: assert property (line_seen |=> LINE_SIGNAL_DETECT_N_OE && status_reg == STAT_LINE_DET)
    else $error("detect pin not pulled");
  powerup_release_a: assert property (powerup_taken |-> ##2 !LINE_SIGNAL_DETECT_N_OE)
    else $error("detect pin not released");
  te_info1_a: assert property (te_req_idle |-> ##2 TX_INFO == INFO_1) else $error("no INFO1");
  te_info3_a: assert property ((st_reg == S_REQ && RX_INFO == INFO_2 && !cmd_go_reg) |-> ##2 TX_INFO == INFO_3)
    else $error("no INFO3");
  nt_pending_a: assert property ((st_reg == S_IDLE && is_nt && RX_INFO == INFO_1 && !cmd_go_reg)
    |=> pending_reg && status_reg == STAT_ACT_PEND) else $error("no pending status");
  nt_ai_a: assert property ((st_reg == S_SYNC && is_nt && RX_INFO == INFO_3 && !cmd_go_reg)
    |=> ATTN_N_OE && status_reg == STAT_ACT_IND) else $error("no network indication");
  nt_info4_a: assert property ((st_reg == S_ARM && is_act_req) |-> ##2 TX_INFO == INFO_4)
    else $error("no INFO4");
  te_active_a: assert property ((st_reg == S_SYNC && !is_nt && RX_INFO == INFO_4 && !cmd_go_reg)
    |=> status_reg == STAT_ACT_IND ##1 st_reg == S_ACT) else $error("no terminal indication");
  fixed_offset_a: assert property ((fixed && TRANSMIT_BIT_CLOCK_EDGE && smp_cnt_reg == 9'h000)
    |-> ##[400:400] RX_SAMPLE) else $error("fixed sample offset wrong");
  eq_off_a: assert property (fixed |=> !EQ_EN) else $error("equalizer on in fixed mode");
  shift_in_a: assert property (@(posedge CONTROL_SHIFT_CLOCK) disable iff (!link_clr_n)
    (bit_cnt_reg != BYTE_BITS) |=> cmd_shift_reg[0] == $past(CMD_SERIAL_IN)) else $error("bit not sampled");
endmodule

// File: rtl/sid_ctrl_pkg.sv
// What this block does
// - Each frame swaps one command for one status
// - Command bits sampled on rising shift clock
// - Status bits launched on falling shift clock
// - Status change pulls attention output low
// - Attention released on first rising edge
// - New command replaces its group's function
// - Adaptive mode locks sampling to received data
// - Fixed mode samples 4 us after transmit edge
// - Equalizer stays off in fixed timing
// - Mode picks timing and activation machine
// - Powered down, line signal drives detect low
// - Power-up releases detect pin, disables detector
// - Terminal power-up then request sends INFO1
// - Network powered up during attempt flags pending
// - Network request after pending sends INFO2
// - Terminal seeing INFO2 sends INFO3 itself
// - Network seeing INFO3 raises activation indication
// - Repeated network request then sends INFO4
// - Terminal seeing INFO4 reports link active
// - No pending change returns all-zero status
// - Command during pending swaps status, releases attention
package sid_ctrl_pkg;
  localparam int SYS_CLK_NS = 10;
  localparam int SAMPLE_OFFSET_NS = 4000;
  // Least time, so round up to whole cycles
  localparam int SAMPLE_OFFSET_CYC = (SAMPLE_OFFSET_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [8:0] SAMPLE_LOAD = 9'(SAMPLE_OFFSET_CYC - 1);
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Command codes
  localparam logic [7:0] CMD_IDLE = 8'hFF;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h00;
  localparam logic [7:0] CMD_DEACT_REQ = 8'h01;
  localparam logic [7:0] CMD_ACT_REQ = 8'h03;
  localparam logic [7:0] CMD_POWER_UP = 8'h20;
  localparam logic [5:0] CMD_MODE_GRP = 6'h01;
  localparam logic [5:0] CMD_FMT_GRP = 6'h02;
  localparam logic [7:0] CMD_EOM_IRQ_ON = 8'h0C;
  localparam logic [7:0] CMD_EOM_IRQ_OFF = 8'h0D;
  localparam logic [7:0] CMD_MF_IRQ_ON = 8'h0E;
  localparam logic [7:0] CMD_MF_IRQ_OFF = 8'h0F;
  localparam logic [7:0] CMD_B1_OFF = 8'h10;
  localparam logic [7:0] CMD_B2_OFF = 8'h11;
  localparam logic [7:0] CMD_B1_ON = 8'h14;
  localparam logic [7:0] CMD_B2_ON = 8'h15;
  localparam logic [7:0] CMD_B_SWAP = 8'h16;
  localparam logic [7:0] CMD_LOOP_LO = 8'h18;
  localparam logic [7:0] CMD_LOOP_HI = 8'h1D;

  // Status codes
  localparam logic [7:0] STAT_NONE = 8'h00;
  localparam logic [7:0] STAT_LINE_DET = 8'h30;
  localparam logic [7:0] STAT_ACT_PEND = 8'h31;
  localparam logic [7:0] STAT_ACT_IND = 8'h32;
  localparam logic [7:0] STAT_ERR = 8'h33;
  localparam logic [7:0] STAT_LINK_DOWN = 8'h34;

  typedef enum logic [1:0] {
    MODE_NET_ADAPT = 2'h0, MODE_NET_FIXED = 2'h1, MODE_TERM_MASTER = 2'h2, MODE_TERM_SLAVE = 2'h3
  } mode_t;
  typedef enum logic [2:0] {
    INFO_0 = 3'h0, INFO_1 = 3'h1, INFO_2 = 3'h2, INFO_3 = 3'h3, INFO_4 = 3'h4, INFO_LOST = 3'h5
  } info_t;
  typedef enum logic [2:0] {
    S_DOWN = 3'h0, S_IDLE = 3'h1, S_REQ = 3'h3, S_SYNC = 3'h2, S_ARM = 3'h6, S_ACT = 3'h7, S_PEND = 3'h5
  } act_state_t;
  typedef struct packed {
    logic [1:0] fmt;
    logic b1_en;
    logic b2_en;
    logic b_swap;
    logic eom_ie;
    logic mf_ie;
    logic [2:0] loop_sel;
  } cfg_t;

  localparam cfg_t CFG_RESET = cfg_t'(10'h000);
  localparam mode_t MODE_RESET = MODE_TERM_MASTER;
endpackage

// File: rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Async reset, low
  input wire logic din, // Foreign level
  output logic dout // Filtered level
);
  logic [2:0] stage_reg;

  // Three-stage chain; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= {3{RESET_VAL}};
    end else begin
      stage_reg <= {stage_reg[1:0], din};
    end
  end

  // Change counts only once last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= RESET_VAL;
    end else if (stage_reg[2] == stage_reg[1]) begin
      dout <= stage_reg[2];
    end
  end
endmodule

// File: tb/ctrl_master.sv
`timescale 1ns/1ps
module ctrl_master (
  output logic sclk, // Shift clock, still between frames
  output logic sel_n, // Frame select, low
  output logic mosi, // Command bit
  input wire logic miso_o, // Status bit from device
  input wire logic miso_oe // Status pin drive enable
);
  logic last = 1'b0;
  logic line;

  // A released status pin shows the inverse of its last bit, never a stale copy
  always @(miso_o or miso_oe) if (miso_oe) last = miso_o;
  assign line = miso_oe ? miso_o : ~last;

  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end

  // one byte each way, select held for eight shift clocks
  // Fewer bits only when a test wants a short, discarded frame
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] stat);
    stat = 8'h00;
    sel_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = cmd[7 - i];
      #24;
      stat = {stat[6:0], line};
      sclk = 1'b1;
      #24;
      sclk = 1'b0;
    end
    #24;
    sel_n = 1'b1;
    mosi = ~mosi; // Unselected data line keeps moving
    #200;
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sid_ctrl_pkg::*;
  logic sys_clk, nrst, sclk, sel_n, cmd_in, so, so_oe, attn_o, attn_oe, det_o, det_oe;
  logic energy, tx_edge, rec_edge, rx_sample, rx_adaptive, eq_en, powered, attn_n, det_n;
  info_t rx_info, tx_info;
  mode_t mode;
  cfg_t cfg, exp_cfg;
  int bad_count, cmp_count, seed, n;
  logic [7:0] st, k;

  // Open-drain attention line with pull-up
  assign attn_n = attn_oe ? attn_o : 1'b1;
  // Open-drain line-detect pin with pull-up
  assign det_n = det_oe ? det_o : 1'b1;

  sid_control i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .CONTROL_SHIFT_CLOCK(sclk), .PORT_SEL_N(sel_n),
    .CMD_SERIAL_IN(cmd_in), .STATUS_SERIAL_OUT(so), .STATUS_SERIAL_OE(so_oe), .ATTN_N_O(attn_o),
    .ATTN_N_OE(attn_oe), .LINE_SIGNAL_DETECT_N_O(det_o), .LINE_SIGNAL_DETECT_N_OE(det_oe),
    .LINE_ENERGY(energy), .RX_INFO(rx_info), .TX_INFO(tx_info), .TRANSMIT_BIT_CLOCK_EDGE(tx_edge),
    .RECOVERED_EDGE(rec_edge), .RX_SAMPLE(rx_sample), .RX_ADAPTIVE(rx_adaptive), .EQ_EN(eq_en),
    .POWERED(powered), .MODE(mode), .CFG(cfg));

  ctrl_master i_master (.sclk(sclk), .sel_n(sel_n), .mosi(cmd_in), .miso_o(so), .miso_oe(so_oe));

  // System clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  task automatic x(input logic [7:0] code);
    i_master.xfer(code, 8, st);
    tk(1);
  endtask

  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Group settings expected after one configuration command
  function automatic cfg_t next_cfg(cfg_t e, logic [7:0] c);
    if (c[7:2] == CMD_FMT_GRP) e.fmt = c[1:0];
    else if (c == CMD_EOM_IRQ_ON) e.eom_ie = 1'b1;
    else if (c == CMD_EOM_IRQ_OFF) e.eom_ie = 1'b0;
    else if (c == CMD_MF_IRQ_ON) e.mf_ie = 1'b1;
    else if (c == CMD_MF_IRQ_OFF) e.mf_ie = 1'b0;
    else if (c == CMD_B1_ON) e.b1_en = 1'b1;
    else if (c == CMD_B1_OFF) e.b1_en = 1'b0;
    else if (c == CMD_B2_ON) e.b2_en = 1'b1;
    else if (c == CMD_B2_OFF) e.b2_en = 1'b0;
    else if (c == CMD_B_SWAP) e.b_swap = ~e.b_swap;
    else if (c >= CMD_LOOP_LO && c <= CMD_LOOP_HI) e.loop_sel = 3'(c - CMD_LOOP_LO);
    return e;
  endfunction

  // Hang guard, well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    energy = 1'b0;
    tx_edge = 1'b0;
    rec_edge = 1'b0;
    rx_info = INFO_0;
    seed = 32'h5B41DC6E;
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    tk(5);
    chk("tx_info", INFO_0, tx_info);
    chk("mode", MODE_TERM_MASTER, mode);
    chk("cfg", CFG_RESET, cfg);
    chk("powered", 0, powered);
    // Line energy while powered down
    energy = 1'b1;
    tk(10);
    chk("det_oe", 1, det_oe);
    chk("det_n", 0, det_n);
    chk("attn_n", 0, attn_n);
    x(CMD_IDLE);
    chk("status", STAT_LINE_DET, st);
    chk("attn_oe", 0, attn_oe);
    x(CMD_IDLE);
    chk("status", STAT_NONE, st);
    // Short frame must be dropped
    i_master.xfer(CMD_POWER_UP, 4, st);
    tk(1);
    chk("powered", 0, powered);
    // Network, fixed timing
    x({6'h01, MODE_NET_FIXED});
    chk("mode", MODE_NET_FIXED, mode);
    chk("rx_adaptive", 0, rx_adaptive);
    rx_info = INFO_1;
    x(CMD_POWER_UP);
    chk("powered", 1, powered);
    chk("det_oe", 0, det_oe);
    chk("eq_en", 0, eq_en);
    tk(10);
    chk("det_oe", 0, det_oe);
    chk("det_n", 1, det_n);
    x(CMD_IDLE);
    chk("status", STAT_ACT_PEND, st);
    tx_edge = 1'b1;
    tk(1);
    tx_edge = 1'b0;
    // The edge that takes the pulse is the first of the count
    n = 1;
    while (rx_sample !== 1'b1 && n < 1000) begin
      tk(1);
      n++;
    end
    chk("sample_delay", SAMPLE_OFFSET_CYC, n);
    x(CMD_ACT_REQ);
    chk("tx_info", INFO_2, tx_info);
    rx_info = INFO_3;
    tk(6);
    x(CMD_IDLE);
    chk("status", STAT_ACT_IND, st);
    x(CMD_ACT_REQ);
    chk("tx_info", INFO_4, tx_info);
    chk("eq_en", 0, eq_en);
    // Back to power down, then terminal mode
    energy = 1'b0;
    rx_info = INFO_0;
    x(CMD_POWER_DOWN);
    chk("powered", 0, powered);
    x({6'h01, MODE_TERM_MASTER});
    x(CMD_IDLE);
    chk("rx_adaptive", 1, rx_adaptive);
    x(CMD_POWER_UP);
    chk("eq_en", 1, eq_en);
    // Recovered timing passes through as a one-cycle pulse
    rec_edge = 1'b1;
    tk(1);
    rec_edge = 1'b0;
    chk("rx_sample", 1, rx_sample);
    tk(1);
    chk("rx_sample", 0, rx_sample);
    x(CMD_ACT_REQ);
    chk("tx_info", INFO_1, tx_info);
    rx_info = INFO_2;
    tk(6);
    chk("tx_info", INFO_3, tx_info);
    rx_info = INFO_4;
    tk(6);
    chk("attn_oe", 1, attn_oe);
    // Pending status traded for an ordinary command
    x(CMD_B1_ON);
    chk("status", STAT_ACT_IND, st);
    chk("attn_oe", 0, attn_oe);
    exp_cfg = next_cfg(CFG_RESET, CMD_B1_ON);
    // Every setting code once, then random ones
    for (int i = 0; i < 60; i++) begin
      k = (i < 22) ? 8'h08 + 8'(i) : 8'h08 + 8'($unsigned($random(seed)) % 22);
      if (k == 8'h12 || k == 8'h13 || k == 8'h17) continue;
      x(k);
      exp_cfg = next_cfg(exp_cfg, k);
      chk("status", STAT_NONE, st);
      chk("cfg", exp_cfg, cfg);
    end
    // Lost framing while active, then deactivate
    rx_info = INFO_LOST;
    tk(6);
    x(CMD_IDLE);
    chk("status", STAT_ERR, st);
    x(CMD_DEACT_REQ);
    chk("tx_info", INFO_0, tx_info);
    chk("powered", 1, powered);
    // Adaptive network: request from idle goes straight to INFO2
    x({6'h01, MODE_NET_ADAPT});
    chk("mode", MODE_NET_ADAPT, mode);
    chk("rx_adaptive", 1, rx_adaptive);
    x(CMD_ACT_REQ);
    chk("tx_info", INFO_2, tx_info);
    chk("eq_en", 1, eq_en);
    x({6'h01, MODE_TERM_SLAVE});
    chk("mode", MODE_TERM_SLAVE, mode);
    summarize();
  end
endmodule
